/* include/peb_pkg.sv */
// Constants and types for the local expansion bus port
package peb_pkg;
    localparam int LAD_W        = 32;            // Local address/data width
    localparam int LANE_N       = 4;             // Byte lanes
    localparam int ADDR_LO      = 2;             // Lowest forwarded host address bit
    localparam int ADDR_HI      = 19;            // Highest forwarded host address bit
    localparam int ADDR_FWD_W   = ADDR_HI - ADDR_LO + 1;
    localparam int BASE_LO      = 20;            // Lowest host address bit compared to base
    localparam int BASE_W       = LAD_W - BASE_LO;
    localparam logic [BASE_W-1:0] BASE_RST = 12'h000;
    localparam logic [LANE_N-1:0] LANES_IDLE = 4'hf;
    localparam int DATA_CYC     = 2;             // Default strobe cycles per access
    typedef enum logic [2:0] {
        PEB_IDLE,
        PEB_REQ,
        PEB_ADDR,
        PEB_DATA,
        PEB_DONE
    } peb_state_e;
endpackage

/* logic/peb_local_bus.sv */
// Host-to-local expansion bus bridge: decode, arbitration, address/data and strobes
//
// Notes on behaviour
// - Local clock out is inverted host clock
// - Address phase: host addr 19:2 on 17:0
// - Address phase: upper local bits driven zero
// - Forward only when upper address matches base
// - Data phase passes host data unchanged
// - Four active-low lane selects, one per byte
// - Only data-phase byte enables reach selects
// - Lane selects high outside data phase
// - Default style: write strobe low, rising defines
// - Default style: read strobe low, high on writes
// - Alternate style: direction high read, low write
// - Alternate style: data strobe low through data phase
// - Default style: latch enable low through data
// - Alternate style: address strobe low entire cycle
// - Local interrupt forwarded to host interrupt B
// - Request local bus before any access
// - Acknowledge grant; hold cycle until released
`timescale 1ns/100ps
module peb_local_bus
    import peb_pkg::*;
#(
    parameter int DATA_CYCLES = DATA_CYC
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic              clk_en,
    input  wire logic              alt_strobe_mode,
    input  wire logic [BASE_W-1:0] base_addr,
    input  wire logic              host_addr_valid,
    input  wire logic [LAD_W-1:0]  host_ad,
    input  wire logic [LANE_N-1:0] host_cbe_n,
    input  wire logic              host_write,
    input  wire logic              host_data_valid,
    output logic                   host_hit,
    output logic                   host_busy,
    output logic                   host_done,
    output logic [LAD_W-1:0]       host_rdata,
    input  wire logic              local_interrupt_in_n,
    output logic                   host_intb_n,
    output logic                   local_bus_clock_out,
    input  wire logic [LAD_W-1:0]  local_addr_data_in,
    output logic [LAD_W-1:0]       local_addr_data_out,
    output logic                   local_addr_data_oe,
    output logic [LANE_N-1:0]      local_byte_select_n,
    output logic                   write_strobe_n,
    output logic                   read_strobe_n,
    output logic                   address_strobe_n,
    output logic                   data_strobe_n,
    output logic                   local_bus_request_n,
    input  wire logic              local_bus_grant_n,
    output logic                   grant_acknowledge_n
);
    initial begin
        if (DATA_CYCLES < 1 || DATA_CYCLES > 15) begin
            $error("DATA_CYCLES out of range");
        end
    end

    // Registers
    peb_state_e        state_ff, nxt_state;
    logic [LAD_W-1:0]  ad_ff, nxt_ad;
    logic [LANE_N-1:0] be_ff, nxt_be;
    logic              wr_ff, nxt_wr;
    logic [3:0]        cnt_ff, nxt_cnt;
    logic [LAD_W-1:0]  rdata_ff, nxt_rdata;
    logic              intb_ff;

    // Base compare and phase decode
    wire match     = host_addr_valid && (host_ad[LAD_W-1:BASE_LO] == base_addr);
    wire granted   = !local_bus_grant_n;
    wire in_addr   = (state_ff == PEB_ADDR);
    wire in_data   = (state_ff == PEB_DATA);
    wire in_access = in_addr || in_data;
    wire last_data = in_data && (cnt_ff == 4'(DATA_CYCLES - 1));

    // Local clock is the inverse of the block clock
    assign local_bus_clock_out = ~ref_clk;

    // Next state
    always_comb begin
        nxt_state = state_ff;
        nxt_ad    = ad_ff;
        nxt_be    = be_ff;
        nxt_wr    = wr_ff;
        nxt_cnt   = cnt_ff;
        nxt_rdata = rdata_ff;
        case (state_ff)
            PEB_IDLE: begin
                if (match) begin
                    nxt_ad    = {{(LAD_W - ADDR_FWD_W){1'b0}}, host_ad[ADDR_HI:ADDR_LO]};
                    nxt_wr    = host_write;
                    nxt_state = PEB_REQ;
                end
            end
            PEB_REQ: begin
                if (granted && host_data_valid) begin
                    nxt_state = PEB_ADDR;
                end
            end
            PEB_ADDR: begin
                nxt_ad    = host_ad;
                nxt_be    = host_cbe_n;
                nxt_cnt   = 4'h0;
                nxt_state = PEB_DATA;
            end
            PEB_DATA: begin
                nxt_cnt = cnt_ff + 4'h1;
                if (last_data) begin
                    nxt_rdata = local_addr_data_in;
                    nxt_state = PEB_DONE;
                end
            end
            PEB_DONE: begin
                nxt_be    = LANES_IDLE;
                nxt_state = PEB_IDLE;
            end
            default: begin
                nxt_state = PEB_IDLE;
            end
        endcase
    end

    // State registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= PEB_IDLE;
            ad_ff    <= '0;
            be_ff    <= LANES_IDLE;
            wr_ff    <= 1'b0;
            cnt_ff   <= 4'h0;
            rdata_ff <= '0;
            intb_ff  <= 1'b1;
        end else if (clk_en) begin
            state_ff <= nxt_state;
            ad_ff    <= nxt_ad;
            be_ff    <= nxt_be;
            wr_ff    <= nxt_wr;
            cnt_ff   <= nxt_cnt;
            rdata_ff <= nxt_rdata;
            intb_ff  <= local_interrupt_in_n;
        end
    end

    // Host-side status
    assign host_hit   = match && (state_ff == PEB_IDLE);
    assign host_busy  = (state_ff != PEB_IDLE);
    assign host_done  = (state_ff == PEB_DONE);
    assign host_rdata = rdata_ff;
    assign host_intb_n = intb_ff;

    // Local address/data drive; floats during read data phase
    assign local_addr_data_out = ad_ff;
    assign local_addr_data_oe  = in_addr || (in_data && wr_ff);

    // One chip select per byte lane, each idle outside the data phase
    generate
        for (genvar lane = 0; lane < LANE_N; lane++) begin : g_lane
            assign local_byte_select_n[lane] = in_data ? be_ff[lane] : LANES_IDLE[lane];
        end
    endgenerate

    // Arbitration handshake
    assign local_bus_request_n = !(state_ff == PEB_REQ);
    assign grant_acknowledge_n = !in_access;

    // Picks the pin level for the strobe style in use
    function automatic logic style_pick(input logic alt_sel, input logic alt_lvl,
                                        input logic def_lvl);
        style_pick = alt_sel ? alt_lvl : def_lvl;
    endfunction

    // Strobes in the two styles; unused style pins sit high
    assign address_strobe_n = !(in_access);
    assign write_strobe_n   = style_pick(alt_strobe_mode, !(in_access && wr_ff), !(in_data && wr_ff));
    assign read_strobe_n    = style_pick(alt_strobe_mode, 1'b1, !(in_data && !wr_ff));
    assign data_strobe_n    = style_pick(alt_strobe_mode, !in_data, 1'b1);

    // Checks
    lanes_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !in_data |-> local_byte_select_n == LANES_IDLE)
        else $error("lane select active outside data phase");
    addr_map_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        in_addr |-> local_addr_data_out[LAD_W-1:ADDR_FWD_W] == '0)
        else $error("upper address bits not zero");
    addr_fwd_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_ff == PEB_IDLE && match && clk_en) |=>
        ad_ff[ADDR_FWD_W-1:0] == $past(host_ad[ADDR_HI:ADDR_LO]))
        else $error("forwarded address wrong");
    base_hit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_ff == PEB_IDLE && clk_en && !match) |=> state_ff == PEB_IDLE)
        else $error("cycle forwarded without base match");
    read_high_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (in_access && wr_ff) |-> read_strobe_n)
        else $error("read strobe low during write");
    ack_grant_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $fell(grant_acknowledge_n) |-> $past(granted))
        else $error("acknowledge without grant");
    req_first_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $fell(grant_acknowledge_n) |-> $past(!local_bus_request_n))
        else $error("access without request");
    release_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        host_done |-> local_bus_request_n && grant_acknowledge_n)
        else $error("bus held after access");
    dstrobe_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (in_data && alt_strobe_mode) |-> !data_strobe_n && !address_strobe_n)
        else $error("alternate strobes not low");
    ale_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (in_data && !alt_strobe_mode) |-> !address_strobe_n)
        else $error("latch enable high in data phase");
    dir_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (in_access && alt_strobe_mode) |-> write_strobe_n == !wr_ff)
        else $error("direction wrong");

    // Strobe levels per style and direction
    // Default write strobe low through a write data phase
    wstr_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (in_data && wr_ff && !alt_strobe_mode) |-> !write_strobe_n)
        else $error("write strobe not low on write");
    // Default write strobe stays high on reads
    wstr_hi_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (in_access && !wr_ff && !alt_strobe_mode) |-> write_strobe_n)
        else $error("write strobe low on read");
    // Default read strobe low through a read data phase
    rstr_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (in_data && !wr_ff && !alt_strobe_mode) |-> !read_strobe_n)
        else $error("read strobe not low on read");
    // Alternate direction low for the whole write
    dir_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (in_access && wr_ff && alt_strobe_mode) |-> !write_strobe_n)
        else $error("direction not low on write");
    // Read strobe unused in alternate style
    alt_rd_hi_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        alt_strobe_mode |-> read_strobe_n)
        else $error("read strobe active in alternate style");
    // Data strobe unused in default style
    def_ds_hi_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !alt_strobe_mode |-> data_strobe_n)
        else $error("data strobe active in default style");
    // All strobes quiet while idle
    idle_quiet_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_ff == PEB_IDLE) |-> write_strobe_n && read_strobe_n && data_strobe_n
        && address_strobe_n)
        else $error("strobe active while idle");
    // Selects follow the captured data-phase enables
    sel_copy_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        in_data |-> local_byte_select_n == be_ff)
        else $error("lane select differs from enables");
    // Enables captured from the host data phase only
    be_capture_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (in_addr && clk_en) |=> local_byte_select_n == $past(host_cbe_n))
        else $error("lane select not from data phase");
    // Host data passed unchanged into the data phase
    data_pass_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (in_addr && clk_en) |=> local_addr_data_out == $past(host_ad))
        else $error("data phase word altered");
    // Bridge drives the bus during the address phase
    addr_oe_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        in_addr |-> local_addr_data_oe)
        else $error("address not driven");
    // Upper bits already clear while waiting for the bus
    addr_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_ff == PEB_REQ) |-> local_addr_data_out[LAD_W-1:ADDR_FWD_W] == '0)
        else $error("upper address bits set while waiting");
    // Peripheral owns the bus during read data
    oe_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (in_data && !wr_ff) |-> !local_addr_data_oe)
        else $error("bridge drives during read data");
    // Data phase lasts its full count
    cnt_span_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (in_data && !last_data && clk_en) |=> in_data)
        else $error("data phase cut short");
    // Local clock is the inverse of the block clock
    clk_inv_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        local_bus_clock_out != ref_clk)
        else $error("local clock not inverted");
    // Interrupt copied one cycle later
    intb_fwd_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en |=> host_intb_n == $past(local_interrupt_in_n))
        else $error("interrupt not forwarded");
    // Request held until the bus is granted
    req_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_ff == PEB_REQ && clk_en && !(granted && host_data_valid))
        |=> !local_bus_request_n)
        else $error("request dropped before grant");
    // No acknowledge while still requesting
    ack_rel_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_ff == PEB_REQ) |-> grant_acknowledge_n)
        else $error("acknowledge before grant taken");
    // Acknowledge held through the data phase
    ack_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        in_data |-> !grant_acknowledge_n)
        else $error("acknowledge dropped in data phase");
    // Done pulse lasts one cycle
    done_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        host_done |=> !host_done)
        else $error("done longer than one cycle");
    // Bridge stops driving once the access ends
    rel_oe_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        host_done |-> !local_addr_data_oe)
        else $error("bus driven after access");
    // No new hit while an access runs
    hit_busy_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        host_busy |-> !host_hit)
        else $error("hit taken while busy");
endmodule

/* bench/peb_far_model.sv */
// Far-side model: local arbiter and one 32-bit-wide peripheral
`timescale 1ns/100ps
module peb_far_model
    import peb_pkg::*;
(
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             sole_master,
    input  wire logic [LAD_W-1:0] rd_word,
    input  wire logic             local_bus_request_n,
    input  wire logic             local_addr_data_oe,
    input  wire logic             read_strobe_n,
    input  wire logic             data_strobe_n,
    output logic                  local_bus_grant_n,
    output logic [LAD_W-1:0]      local_addr_data_in
);
    logic [1:0] wait_ff;
    // Grant two cycles after a request, or always when no other master exists
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_ff <= 2'h0;
        end else begin
            wait_ff <= local_bus_request_n ? 2'h0 : {wait_ff[0], 1'b1};
        end
    end
    assign local_bus_grant_n = sole_master ? 1'b0 : ~wait_ff[1];
    // Peripheral drives only while enabled and the bridge is off the bus
    assign local_addr_data_in = (!local_addr_data_oe && !(read_strobe_n && data_strobe_n)) ?
                                rd_word : ~rd_word;
endmodule

/* bench/tb_peb_local_bus.sv */
// Self-checking bench for the local expansion bus bridge
`timescale 1ns/100ps
module tb_peb_local_bus
    import peb_pkg::*;
;
`define CHK(nm, ex, sn) begin checks++; if ((sn) !== (ex)) begin err_total++; \
    $display("ERROR %s expected %h seen %h", nm, ex, sn); end end
    localparam int DC = 3;
    logic        ref_clk = 1'b0, rst_n = 1'b0, alt = 1'b0, sole = 1'b1, av = 1'b0;
    logic        wr = 1'b0, irq_n = 1'b1;
    logic [11:0] base = 12'ha5c;
    logic [31:0] had = 32'h0, rdw = 32'h0, rdata, ldi, ldo;
    logic [3:0]  cbe = 4'hf, sel_n;
    logic        hit, busy, done, intb_n, lclk, oe, wr_n, rd_n, as_n, ds_n, req_n, gnt_n, ack_n;
    int          err_total = 0, checks = 0;
    // Block clock
    always #20 ref_clk = ~ref_clk;
    peb_local_bus #(.DATA_CYCLES(DC)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1),
        .alt_strobe_mode(alt), .base_addr(base), .host_addr_valid(av), .host_ad(had),
        .host_cbe_n(cbe), .host_write(wr), .host_data_valid(1'b1), .host_hit(hit),
        .host_busy(busy), .host_done(done), .host_rdata(rdata), .local_interrupt_in_n(irq_n),
        .host_intb_n(intb_n), .local_bus_clock_out(lclk), .local_addr_data_in(ldi),
        .local_addr_data_out(ldo), .local_addr_data_oe(oe), .local_byte_select_n(sel_n),
        .write_strobe_n(wr_n), .read_strobe_n(rd_n), .address_strobe_n(as_n),
        .data_strobe_n(ds_n), .local_bus_request_n(req_n), .local_bus_grant_n(gnt_n),
        .grant_acknowledge_n(ack_n));
    peb_far_model u_far (.ref_clk(ref_clk), .rst_n(rst_n), .sole_master(sole), .rd_word(rdw),
        .local_bus_request_n(req_n), .local_addr_data_oe(oe), .read_strobe_n(rd_n),
        .data_strobe_n(ds_n), .local_bus_grant_n(gnt_n), .local_addr_data_in(ldi));
    task automatic test_done();
        if (err_total == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // One forwarded access, watched cycle by cycle until completion
    task automatic access(input logic w, input logic [31:0] a, input logic [31:0] d,
                          input logic [3:0] be);
        int n, nsel;
        logic [1:0] seen;
        n = 0; nsel = 0; seen = 2'h0;
        wr = w; had = a; cbe = ~be; av = 1'b1; rdw = ~d;
        #1 `CHK("hit", 1'b1, hit)
        @(posedge ref_clk); #2;
        av = 1'b0; had = d; cbe = be;
        `CHK("busy", 1'b1, busy)
        while (done !== 1'b1 && n < 40) begin
            if (req_n === 1'b0 && ack_n === 1'b1) seen[0] = 1'b1;
            if (ack_n === 1'b0) begin
                seen[1] = 1'b1;
                `CHK("astr", 1'b0, as_n)
                if (w && !alt) `CHK("rdhi", 1'b1, rd_n)
            end
            if (sel_n !== 4'hf) begin
                nsel++;
                `CHK("sel", be, sel_n)
                `CHK("dstr", {~w, alt ? 1'b0 : w}, {wr_n, alt ? ds_n : rd_n})
                if (w) `CHK("wdata", d, ldo)
                `CHK("oe", w, oe)
            end else if (ack_n === 1'b0 && oe === 1'b1) begin
                `CHK("addr", {14'h0, a[19:2]}, ldo)
            end
            @(posedge ref_clk); #2;
            n++;
        end
        `CHK("hs", 2'h3, seen)
        if (sole) `CHK("lat", 2 + DC, n)
        `CHK("nsel", DC, nsel)
        if (!w) `CHK("rdata", ~d, rdata)
        @(posedge ref_clk); #2;
        `CHK("rel", 3'h7, {req_n, ack_n, &sel_n})
    endtask
    // Address outside the window is never forwarded
    task automatic miss();
        had = 32'h35c0_0040; av = 1'b1;
        #1 `CHK("nohit", 1'b0, hit)
        @(posedge ref_clk); #2;
        av = 1'b0;
        repeat (6) begin
            @(posedge ref_clk); #2;
            `CHK("noreq", 1'b1, req_n)
        end
    endtask
    // Interrupt forwarding and local clock phase
    task automatic irq_clk();
        irq_n = 1'b0;
        repeat (2) @(posedge ref_clk);
        #2 `CHK("intb", 1'b0, intb_n)
        irq_n = 1'b1;
        repeat (2) @(posedge ref_clk);
        #2 `CHK("intb", 1'b1, intb_n)
        #10 `CHK("lclk", ~ref_clk, lclk)
        #20 `CHK("lclk", ~ref_clk, lclk)
    endtask
    // Main sequence
    initial begin
        repeat (16) @(posedge ref_clk);
        #2 rst_n = 1'b1;
        access(1'b1, 32'ha5c8_7654, 32'hdead_beef, 4'h0);
        access(1'b0, 32'ha5cf_fffc, 32'h1234_5678, 4'h5);
        alt = 1'b1;
        access(1'b1, 32'ha5c0_0004, 32'h0f0f_a5a5, 4'ha);
        access(1'b0, 32'ha5c4_0008, 32'hc3c3_3c3c, 4'he);
        sole = 1'b0;
        access(1'b0, 32'ha5c2_0010, 32'h8001_7ffe, 4'h3);
        alt = 1'b0;
        access(1'b1, 32'ha5c1_0020, 32'h5a5a_0ff0, 4'h7);
        miss();
        irq_clk();
        test_done();
    end
    // Watchdog
    initial begin
        #80000;
        err_total++;
        test_done();
    end
endmodule
